// [hw/lss_pkg.sv]
// package for the logic supply supervisor: timing, register layout, states, carriers
// assumes a 200 MHz core clock and analog comparators outside this logic
package lss_pkg;
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned FILTER_TIME_US = 100;
    localparam int unsigned FILTER_MIN_US = 60;
    localparam int unsigned FILTER_MAX_US = 135;
    localparam int unsigned FILTER_CYCLES_DFLT = (FILTER_TIME_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned POR_DELAY_US = 220;
    localparam int unsigned POR_CYCLES_DFLT = (POR_DELAY_US * 1000000) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 17;

    // supply_supervisor_status_config layout
    localparam int unsigned BIT_OV_OK = 0;
    localparam int unsigned BIT_UV_OK = 1;
    localparam int unsigned BIT_SUPPLY_OK = 2;
    localparam int unsigned BIT_OV_LATCH = 3;
    localparam int unsigned BIT_TEST_SEL = 6;
    localparam int unsigned BIT_TEST_OFF = 7;
    localparam logic [1:0] TEST_OV = 2'h0;
    localparam logic [1:0] TEST_UV = 2'h1;
    localparam logic [1:0] CFG_TEST_RESET = 2'h2;
    localparam logic CFG_LATCH_RESET = 1'h0;

    localparam int unsigned SYNC_W = 6;
    localparam int unsigned CH_OV = 0;
    localparam int unsigned CH_UV = 1;

    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_RESET = 2'b01,
        ST_DELAY = 2'b10,
        ST_RUN = 2'b11
    } lss_state_e;

    typedef struct packed {
        logic io_supply_low;
        logic above_func_reset;
        logic above_por;
        logic above_upper;
        logic below_lower;
    } lss_cmp_s;
endpackage : lss_pkg

// [hw/lss_supervisor.sv]
// logic supply supervisor: power-up sequence, supply window filter, bridge enable pin,
// overvoltage latch, threshold test mode and serial/status-flag mode select.
// assumes raw asynchronous comparator levels and a same-clock register strobe from SPI logic.
// Overview of operation
// R01 - above functional reset level, keep stages off and registers cleared until reset ends
// R02 - after supply passes power-on threshold, run only once power-on delay elapses
// R03 - supply outside window switches stages off and pulls enable pin low
// R04 - window detection passes a glitch filter ignoring short excursions
// R05 - filter needs condition to persist for about 100 us
// R06 - supervisor state is readable in the status/config register
// R07 - enable pin held low externally turns the stages off
// R08 - supply fault keeps stages off even if the pin is forced high
// R09 - during over or undervoltage switch-on is refused, switch-off always honoured
// R10 - drop below power-on threshold switches all off at once, unfiltered, pin low
// R11 - monitor configuration and fault detail only available in serial mode
// R12 - status-flag mode keeps default limits, no test, no overvoltage latch
// R13 - after undervoltage, release pin and resume only after filter interval
// R14 - host must rewrite output source and drive bits after recovery
// R15 - no new failure logging during fault; configuration writes still accepted
// R16 - power-on reset returns every register to default
// R17 - overvoltage for the filter interval shuts stages off and pulls pin low
// R18 - latch bit set keeps pin low after overvoltage until reset or bit write
// R19 - latch bit clear releases pin once back in range and filter expired
// R20 - host uses test mode only in serial mode with latch cleared first
// R21 - writing 00 in top bits lowers upper limit; bits 2 and 0 then read low
// R22 - writing 01 in top bits raises lower limit; bits 2 and 1 then read low
// R23 - low output-buffer supply selects status-flag mode and disables serial port
// R24 - comparators synchronised; filters are counters restarting on condition change
`timescale 1ns/1ps
module lss_supervisor
    import lss_pkg::*;
#(
    parameter int unsigned FILTER_CYCLES = FILTER_CYCLES_DFLT,
    parameter int unsigned POR_CYCLES = POR_CYCLES_DFLT
)
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // analog comparator levels, asynchronous
    input wire lss_cmp_s cmp_in,
    // bridge enable pin, active high: a high level allows the stages, the device only pulls it low
    input wire logic bridge_enable_io_in,
    output logic bridge_enable_io_out,
    output logic bridge_enable_io_oe_out,
    // register port from serial frame logic
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // controls to the rest of the device and the analog front end
    output logic stage_enable_out,
    output logic diag_log_enable_out,
    output logic regs_reset_out,
    output logic serial_enable_out,
    output logic status_flag_diag_mode_out,
    output logic upper_limit_test_out,
    output logic lower_limit_test_out
);
    logic [SYNC_W-1:0] raw_w;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    lss_cmp_s cmp_s;
    logic pin_high_s;
    lss_state_e state_q;
    lss_state_e state_d;
    logic [CNT_W-1:0] dly_cnt_q;
    logic dly_done_w;
    logic [1:0] filt_raw_w;
    logic [1:0] filt_q;
    logic [CNT_W-1:0] filt_cnt_q [2];
    logic [1:0] test_sel_q;
    logic ov_latch_sel_q;
    logic ov_latched_q;
    logic sf_mode_w;
    logic running_w;
    logic fault_w;
    logic latch_eff_w;
    logic cfg_wr_w;
    logic latch_change_w;
    logic [7:0] status_w;

    assign raw_w = {bridge_enable_io_in, cmp_in};

    // [R24] two-stage synchroniser for every asynchronous level
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in)
                begin
                    sync1_q[gi] <= 1'h0;
                    sync2_q[gi] <= 1'h0;
                end
                else
                begin
                    sync1_q[gi] <= raw_w[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    assign cmp_s = lss_cmp_s'(sync2_q[SYNC_W-2:0]);
    assign pin_high_s = sync2_q[SYNC_W-1];
    assign sf_mode_w = cmp_s.io_supply_low; // [R23]

    assign dly_done_w = (dly_cnt_q == CNT_W'(POR_CYCLES - 1));

    // power-up sequence; a power-on drop is taken at once, not filtered [R10]
    always_comb
    begin
        state_d = state_q;
        if (!cmp_s.above_func_reset)
            state_d = ST_OFF;
        else if (!cmp_s.above_por)
            state_d = ST_RESET; // [R01]
        else
        begin
            case (state_q)
                ST_OFF: state_d = ST_DELAY;
                ST_RESET: state_d = ST_DELAY;
                ST_DELAY:
                begin
                    if (dly_done_w)
                        state_d = ST_RUN; // [R02]
                end
                ST_RUN: state_d = ST_RUN;
                default: state_d = ST_OFF;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            state_q <= ST_OFF;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || state_q != ST_DELAY)
            dly_cnt_q <= '0;
        else
            dly_cnt_q <= dly_cnt_q + CNT_W'(1);
    end

    assign running_w = (state_q == ST_RUN) && cmp_s.above_por;

    // [R04] [R05] [R24] filtered state flips only after the raw level differs for the
    // whole interval; any return to the filtered value restarts the count
    assign filt_raw_w[CH_OV] = cmp_s.above_upper;
    assign filt_raw_w[CH_UV] = cmp_s.below_lower;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_filt
            always_ff @(posedge clk_in)
            begin
                if (!rst_n_in || !cmp_s.above_por)
                begin
                    filt_q[gi] <= 1'h0;
                    filt_cnt_q[gi] <= '0;
                end
                else if (filt_raw_w[gi] == filt_q[gi])
                    filt_cnt_q[gi] <= '0;
                else if (filt_cnt_q[gi] == CNT_W'(FILTER_CYCLES - 1))
                begin
                    filt_q[gi] <= filt_raw_w[gi];
                    filt_cnt_q[gi] <= '0;
                end
                else
                    filt_cnt_q[gi] <= filt_cnt_q[gi] + CNT_W'(1);
            end
        end
    endgenerate

    // configuration writes only in serial mode and while running [R11] [R15]
    assign cfg_wr_w = reg_wr_in && running_w && !sf_mode_w;
    assign latch_change_w = cfg_wr_w && (reg_wdata_in[BIT_OV_LATCH] != ov_latch_sel_q);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !running_w)
        begin
            test_sel_q <= CFG_TEST_RESET; // [R16]
            ov_latch_sel_q <= CFG_LATCH_RESET;
        end
        else if (cfg_wr_w)
        begin
            test_sel_q <= reg_wdata_in[BIT_TEST_OFF:BIT_TEST_SEL]; // [R21] [R22]
            ov_latch_sel_q <= reg_wdata_in[BIT_OV_LATCH];
        end
    end

    // latch is ignored in status-flag mode [R12]
    assign latch_eff_w = ov_latch_sel_q && !sf_mode_w;

    // the set wins over a clearing bit write while overvoltage is still present [R18]
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !running_w)
            ov_latched_q <= 1'h0;
        else if (filt_q[CH_OV] && latch_eff_w)
            ov_latched_q <= 1'h1;
        else if (latch_change_w || !latch_eff_w)
            ov_latched_q <= 1'h0; // [R19]
    end

    assign fault_w = filt_q[CH_OV] || filt_q[CH_UV] || ov_latched_q; // [R03] [R17] [R13]

    assign status_w = {test_sel_q, 2'h0, ov_latch_sel_q, !fault_w, !filt_q[CH_UV],
                       !(filt_q[CH_OV] || ov_latched_q)}; // [R06]

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            stage_enable_out <= 1'h0;
            bridge_enable_io_oe_out <= 1'h1;
            diag_log_enable_out <= 1'h0;
            regs_reset_out <= 1'h1;
            serial_enable_out <= 1'h0;
            status_flag_diag_mode_out <= 1'h0;
            upper_limit_test_out <= 1'h0;
            lower_limit_test_out <= 1'h0;
            reg_rdata_out <= 8'h00;
        end
        else
        begin
            // pin level does not override a fault: a forced-high pin still leaves stages off
            stage_enable_out <= running_w && !fault_w && pin_high_s; // [R07] [R08] [R09]
            bridge_enable_io_oe_out <= !running_w || fault_w; // [R03] [R10]
            // a latched overvoltage still counts as a fault, so logging stays off with it
            diag_log_enable_out <= running_w && !fault_w; // [R15]
            regs_reset_out <= !running_w; // [R01] [R16]
            serial_enable_out <= !sf_mode_w; // [R23]
            status_flag_diag_mode_out <= sf_mode_w;
            upper_limit_test_out <= running_w && !sf_mode_w && test_sel_q == TEST_OV; // [R21]
            lower_limit_test_out <= running_w && !sf_mode_w && test_sel_q == TEST_UV; // [R22]
            // fault detail only over the serial port [R11]
            reg_rdata_out <= sf_mode_w ? 8'h00 : status_w;
        end
    end

    // the pin is only ever pulled low, never driven high
    assign bridge_enable_io_out = 1'h0;

    sequence s_por_lost;
        !cmp_s.above_por;
    endsequence
    sequence s_all_off;
        !stage_enable_out && bridge_enable_io_oe_out;
    endsequence

    a_por_drop_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R10]
        s_por_lost |=> s_all_off)
        else $error("stages not off after power-on drop");
    a_por_delay_len: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R02]
        (state_q == ST_DELAY && state_d == ST_RUN) |-> dly_cnt_q == CNT_W'(POR_CYCLES - 1))
        else $error("run entered before power-on delay");
    a_reset_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R01]
        (state_q != ST_RUN) |=> s_all_off and (regs_reset_out && test_sel_q == CFG_TEST_RESET))
        else $error("not held in reset state");
    a_filter_len: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R05]
        $changed(filt_q[CH_OV]) && $past(cmp_s.above_por) && $past(rst_n_in) |->
            $past(filt_cnt_q[CH_OV]) == CNT_W'(FILTER_CYCLES - 1))
        else $error("filter changed before interval");
    a_fault_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R09]
        fault_w |=> s_all_off and (!diag_log_enable_out))
        else $error("stage on or logging during fault");
    a_pin_low_off: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R07]
        !pin_high_s |=> !stage_enable_out)
        else $error("stage on with enable pin low");
    a_latch_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R18]
        ov_latched_q && running_w && !latch_change_w && latch_eff_w |=> ov_latched_q)
        else $error("overvoltage latch released");
    a_sf_defaults: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R12]
        sf_mode_w |=> !upper_limit_test_out && !lower_limit_test_out && !serial_enable_out)
        else $error("test or serial active in status-flag mode");
    a_ov_test_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R21]
        !sf_mode_w && filt_q[CH_OV] |=> !reg_rdata_out[BIT_SUPPLY_OK] && !reg_rdata_out[BIT_OV_OK])
        else $error("overvoltage not shown in status");
    a_uv_test_bits: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R22]
        !sf_mode_w && filt_q[CH_UV] |=> !reg_rdata_out[BIT_SUPPLY_OK] && !reg_rdata_out[BIT_UV_OK])
        else $error("undervoltage not shown in status");
    a_uv_filter_len: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R05]
        $changed(filt_q[CH_UV]) && $past(cmp_s.above_por) && $past(rst_n_in) |->
            $past(filt_cnt_q[CH_UV]) == CNT_W'(FILTER_CYCLES - 1))
        else $error("undervoltage filter changed before interval");
    a_ov_latch_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R18]
        filt_q[CH_OV] && latch_eff_w && running_w |=> ov_latched_q)
        else $error("overvoltage latch not set");
    a_latch_off_free: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R19]
        running_w && !filt_q[CH_OV] && !latch_eff_w |=> !ov_latched_q)
        else $error("overvoltage latch held while disabled");
    a_release_on: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R13]
        running_w && !fault_w && pin_high_s |=> stage_enable_out && !bridge_enable_io_oe_out)
        else $error("stages not resumed after recovery");
    a_sf_readback: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
        sf_mode_w |=> reg_rdata_out == 8'h00)
        else $error("status readback visible in status-flag mode");
    a_write_refused: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R11]
        reg_wr_in && sf_mode_w && running_w |=> $stable(test_sel_q) && $stable(ov_latch_sel_q))
        else $error("configuration write taken in status-flag mode");
    a_serial_mode: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R23]
        !sf_mode_w |=> serial_enable_out && !status_flag_diag_mode_out)
        else $error("serial mode not selected");
    a_regs_default: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R16]
        !running_w |=> regs_reset_out && ov_latch_sel_q == CFG_LATCH_RESET)
        else $error("registers not at default outside run");
    a_lower_test_on: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [R22]
        running_w && !sf_mode_w && test_sel_q == TEST_UV |=> lower_limit_test_out)
        else $error("lower limit test not applied");
endmodule : lss_supervisor

// [testbench/lss_host_model.sv]
// host side of the bridge enable pin: drives it low, leaves it high, or shorts it high
// assumes the device only ever pulls the pin low through its output enable
`timescale 1ns/1ps
module lss_host_model
(
    // device side
    input wire logic dev_oe_in,
    input wire logic dev_out_in,
    // host controls
    input wire logic host_low_in,
    input wire logic short_high_in,
    // resolved pin level
    output logic pin_level_out
);
    wire logic dev_pulls_low = dev_oe_in & ~dev_out_in;
    // an external short is modelled as the strongest driver
    assign pin_level_out = short_high_in ? 1'b1 : ~(host_low_in | dev_pulls_low);
endmodule : lss_host_model

// [testbench/tb_lss_supervisor.sv]
// self-checking bench for the supply supervisor, driving comparators, pin and register strobe
// assumes short filter and power-on counts so the whole run stays small
`timescale 1ns/1ps
module tb_lss_supervisor;
    import lss_pkg::*;
    localparam int F = 8;
    localparam int P = 10;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    lss_cmp_s cmp = '0;
    logic host_low = 1'b0;
    logic short_high = 1'b0;
    logic pin_level;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] rdata;
    logic io_out, oe, stage, diag, regs_rst, ser, sf, up_t, lo_t;
    int n_errors = 0;
    int checks = 0;
    lss_supervisor #(.FILTER_CYCLES(F), .POR_CYCLES(P)) u_lss_supervisor (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cmp_in(cmp),
        .bridge_enable_io_in(pin_level), .bridge_enable_io_out(io_out),
        .bridge_enable_io_oe_out(oe), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata),
        .reg_rdata_out(rdata), .stage_enable_out(stage), .diag_log_enable_out(diag),
        .regs_reset_out(regs_rst), .serial_enable_out(ser), .status_flag_diag_mode_out(sf),
        .upper_limit_test_out(up_t), .lower_limit_test_out(lo_t));
    lss_host_model u_lss_host_model (.dev_oe_in(oe), .dev_out_in(io_out),
        .host_low_in(host_low), .short_high_in(short_high), .pin_level_out(pin_level));
    initial
    begin
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
        end
    endtask : chk_flag
    task automatic chk_byte(input logic [7:0] exp);
        checks++;
        if (rdata !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t readback %h expected %h", $time, rdata, exp);
        end
    endtask : chk_byte
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask : cyc
    // bounded wait for the stage enable level, then both stage and pin pull-down enable are compared
    task automatic wait_stage(input logic exp, input int max);
        int i;
        for (i = 0; i < max && stage !== exp; i++)
            @(negedge clk_in);
        chk_flag(stage, exp);
        chk_flag(oe, ~exp);
    endtask : wait_stage
    task automatic wr(input logic [7:0] d);
        reg_wr = 1'b1;
        reg_wdata = d;
        cyc(1);
        reg_wr = 1'b0;
        cyc(3);
    endtask : wr
    initial
    begin
        cyc(20000);
        n_errors++;
        report_and_stop();
    end
    initial
    begin
        cyc(3);
        chk_flag(oe, 1'b1);
        rst_n_in = 1'b1;
        cmp.above_func_reset = 1'b1;
        cyc(10);
        chk_flag(regs_rst, 1'b1);
        chk_flag(stage, 1'b0);
        cmp.above_por = 1'b1;
        cyc(P);
        chk_flag(stage, 1'b0);
        wait_stage(1'b1, 10);
        chk_byte(8'h87);
        chk_flag(ser, 1'b1);
        // a glitch one cycle short of the filter must be ignored
        cmp.below_lower = 1'b1;
        cyc(F - 1);
        cmp.below_lower = 1'b0;
        cyc(F + 4);
        chk_flag(stage, 1'b1);
        cmp.below_lower = 1'b1;
        cyc(F);
        chk_flag(stage, 1'b1);
        wait_stage(1'b0, 6);
        chk_byte(8'h81);
        chk_flag(diag, 1'b0);
        short_high = 1'b1;
        cyc(4);
        chk_flag(stage, 1'b0);
        short_high = 1'b0;
        cmp.below_lower = 1'b0;
        cyc(F);
        chk_flag(stage, 1'b0);
        wait_stage(1'b1, 6);
        chk_flag(diag, 1'b1);
        host_low = 1'b1;
        cyc(4);
        chk_flag(stage, 1'b0);
        host_low = 1'b0;
        wait_stage(1'b1, 6);
        // host sets the overvoltage latch bit here, test field left at 10 (no test)
        wr(8'h88);
        chk_byte(8'h8F);
        cmp.above_upper = 1'b1;
        wait_stage(1'b0, F + 6);
        cmp.above_upper = 1'b0;
        cyc(2 * F + 6);
        chk_flag(stage, 1'b0);
        chk_byte(8'h8A);
        wr(8'h80);
        wait_stage(1'b1, F + 8);
        cmp.above_upper = 1'b1;
        wait_stage(1'b0, F + 6);
        cmp.above_upper = 1'b0;
        wait_stage(1'b1, F + 8);
        // upper then lower limit test, comparator follows the shifted limit
        wr(8'h00);
        chk_flag(up_t, 1'b1);
        cmp.above_upper = 1'b1;
        cyc(F + 6);
        chk_byte(8'h02);
        wr(8'h80);
        cmp.above_upper = 1'b0;
        chk_flag(up_t, 1'b0);
        wait_stage(1'b1, F + 8);
        chk_byte(8'h87);
        wr(8'h40);
        chk_flag(lo_t, 1'b1);
        cmp.below_lower = 1'b1;
        cyc(F + 6);
        chk_byte(8'h41);
        wr(8'h80);
        cmp.below_lower = 1'b0;
        chk_flag(lo_t, 1'b0);
        wait_stage(1'b1, F + 8);
        chk_byte(8'h87);
        // status-flag mode: no readback, writes ignored, latch off
        wr(8'h88);
        cmp.io_supply_low = 1'b1;
        cyc(4);
        chk_flag(sf, 1'b1);
        chk_flag(ser, 1'b0);
        chk_byte(8'h00);
        wr(8'h00);
        chk_flag(up_t, 1'b0);
        cmp.above_upper = 1'b1;
        wait_stage(1'b0, F + 6);
        cmp.above_upper = 1'b0;
        wait_stage(1'b1, F + 8);
        cmp.io_supply_low = 1'b0;
        cyc(4);
        chk_byte(8'h8F);
        // power-on drop bypasses the filter and restores defaults
        cmp.above_por = 1'b0;
        cyc(3);
        chk_flag(stage, 1'b0);
        chk_flag(oe, 1'b1);
        cyc(1);
        chk_flag(regs_rst, 1'b1);
        cmp.above_por = 1'b1;
        wait_stage(1'b1, P + 10);
        chk_byte(8'h87);
        report_and_stop();
    end
endmodule : tb_lss_supervisor
